/* File: acs_sequencer.sv */
/*
 Conversion mode sequencer: single shot, repeat, sweep and repeat sweep, with result FIFO and threshold.
 Assumes decoded serial commands arrive as one-cycle pulses on clk; sclk, frame_start_n and
 conversion_start_pin come from outside and are synchronised here. The analog core answers
 each conversion with adc_result after a fixed conversion time.
*/
// Overview of operation
// - Single-pass sweep halts channel sequence once FIFO count reaches threshold.
// - After sweep threshold, only FIFO reads, config accesses and power down are accepted.
// - Repeat sweep conversion after threshold clears FIFO and restarts at first channel.
// - Repeat mode stores results in FIFO; single shot bypasses it.
// - Repeat mode restarts conversions on the previously selected channel.
// - Each FIFO-mode conversion starts by chip select frame, start pin pulse or conversion command.
// - Sweep converts channels in programmed order, results stored in that order.
// - Short sampling lasts 12 serial clocks after a 4 clock command phase.
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_sequencer
   import acs_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  sclk,
   input  wire logic                  frame_start_n,
   input  wire logic                  conversion_start_pin,
   input  wire logic                  cmd_valid,
   input  wire acs_cmd_t              cmd_code,
   input  wire acs_chan_t             cmd_chan,
   input  wire logic [`ACS_CFG_W-1:0] cmd_cfg,
   input  wire acs_mode_t             cfg_mode,
   input  wire logic [3:0]            cfg_threshold,
   input  wire logic [11:0]           channel_sequence,
   input  wire acs_result_t           adc_result,
   output logic                       cmd_ignored,
   output logic [`ACS_CFG_W-1:0]      config_register,
   output acs_result_t                data_out,
   output logic                       data_valid,
   output acs_chan_t                  mux_chan,
   output logic                       sampling,
   output logic                       converting,
   output logic                       seq_done,
   output logic                       powered_down,
   output logic [3:0]                 fifo_count
);
   acs_fifo_if fif ();

   acs_result_fifo u_fifo (
      .clk     (clk),
      .reset_n (reset_n),
      .f       (fif.fifo)
   );

   // Two-flop synchronisers for the pins from outside.
   logic [1:0] sclk_sync_reg, fs_sync_reg, cst_sync_reg;
   logic       sclk_d_reg, fs_d_reg, cst_d_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_sync_reg <= 2'h0;
         fs_sync_reg   <= 2'h3;
         cst_sync_reg  <= 2'h3;
         sclk_d_reg    <= 1'b0;
         fs_d_reg      <= 1'b1;
         cst_d_reg     <= 1'b1;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], sclk};
         fs_sync_reg   <= {fs_sync_reg[0], frame_start_n};
         cst_sync_reg  <= {cst_sync_reg[0], conversion_start_pin};
         sclk_d_reg    <= sclk_sync_reg[1];
         fs_d_reg      <= fs_sync_reg[1];
         cst_d_reg     <= cst_sync_reg[1];
      end
   end

   logic sclk_rise, frame_go, pin_go;
   assign sclk_rise = sclk_sync_reg[1] & ~sclk_d_reg;
   assign frame_go  = fs_d_reg & ~fs_sync_reg[1];
   assign pin_go    = cst_d_reg & ~cst_sync_reg[1];

   // Channel of step idx of the programmed sweep order.
   function automatic acs_chan_t seq_chan(input logic [11:0] s, input logic [1:0] idx);
      seq_chan = s[idx*3 +: 3];
   endfunction : seq_chan

   acs_phase_e  ph_reg, ph_next;
   logic [4:0]  sc_reg, sc_next;
   logic [7:0]  cc_reg, cc_next;
   logic [1:0]  step_reg, step_next;
   acs_chan_t   chan_reg, chan_next;
   logic        chsel_reg, chsel_next;
   logic        done_reg, done_next;
   logic        pd_reg, pd_next;
   logic        ign_reg, ign_next;
   logic        dv_reg, dv_next;
   acs_result_t dout_reg, dout_next;
   logic [`ACS_CFG_W-1:0] cfg_reg, cfg_next;
   logic        fifo_mode, thr_hit, start_conv, conv_cmd;

   assign fifo_mode = (cfg_mode != `ACS_MODE_SINGLE);
   assign thr_hit   = fifo_mode && (fif.count >= cfg_threshold) && (cfg_threshold != 4'h0);
   assign conv_cmd  = cmd_valid && (cmd_code == `ACS_CMD_CONV);
   assign start_conv = (frame_go || pin_go || conv_cmd) && (ph_reg == ACS_IDLE);

   // Command handling, phase sequencing and result routing.
   always_comb begin
      ph_next    = ph_reg;
      sc_next    = sc_reg;
      cc_next    = cc_reg;
      step_next  = step_reg;
      chan_next  = chan_reg;
      chsel_next = chsel_reg;
      done_next  = done_reg;
      pd_next    = pd_reg;
      ign_next   = 1'b0;
      dv_next    = 1'b0;
      dout_next  = dout_reg;
      cfg_next   = cfg_reg;
      fif.wr_en   = 1'b0;
      fif.wr_data = adc_result;
      fif.rd_en   = 1'b0;
      fif.clear   = 1'b0;
      if (cmd_valid) begin
         case (cmd_code)
            `ACS_CMD_CFGWR: begin
               cfg_next   = cmd_cfg;
               fif.clear  = 1'b1;
               step_next  = 2'h0;
               chsel_next = 1'b0;
               done_next  = 1'b0;
               pd_next    = 1'b0;
            end
            `ACS_CMD_FIFORD: begin
               if (fif.count != 4'h0) begin
                  fif.rd_en = 1'b1;
                  dout_next = fif.rd_data;
                  dv_next   = 1'b1;
                  // Reading the last word of a finished sweep rearms it without a new configuration.
                  if (fif.count == 4'h1 && cfg_mode == `ACS_MODE_SWEEP) begin
                     done_next = 1'b0;
                  end
               end
            end
            `ACS_CMD_CHANSEL: begin
               if (done_reg && cfg_mode == `ACS_MODE_SWEEP) begin
                  ign_next = 1'b1;
               end else begin
                  chan_next  = cmd_chan;
                  chsel_next = 1'b1;
               end
            end
            `ACS_CMD_PWRDN: begin
               pd_next = 1'b1;
            end
            default: begin
            end
         endcase
      end
      if (start_conv) begin
         if (done_reg && cfg_mode == `ACS_MODE_SWEEP) begin
            ign_next = 1'b1;
         end else if (!cfg_mode[1] && !chsel_reg) begin
            ign_next = 1'b1;
         end else begin
            if (done_reg && cfg_mode == `ACS_MODE_RSWEEP) begin
               fif.clear = 1'b1;
               step_next = 2'h0;
               done_next = 1'b0;
            end else if (done_reg && cfg_mode == `ACS_MODE_REPEAT) begin
               fif.clear = 1'b1;
               done_next = 1'b0;
            end
            if (cfg_mode[1]) begin
               chan_next = seq_chan(channel_sequence,
                  (done_reg && cfg_mode == `ACS_MODE_RSWEEP) ? 2'h0 : step_reg);
            end
            pd_next = 1'b0;
            ph_next = ACS_COMMAND;
            sc_next = 5'h0;
         end
      end
      case (ph_reg)
         ACS_COMMAND: begin
            if (sclk_rise) begin
               sc_next = sc_reg + 5'h1;
               if (sc_reg == 5'(`ACS_CMD_SCLKS - 1)) begin
                  ph_next = ACS_SAMPLE;
                  sc_next = 5'h0;
               end
            end
         end
         ACS_SAMPLE: begin
            if (sclk_rise) begin
               sc_next = sc_reg + 5'h1;
               if (sc_reg == 5'(`ACS_SAMPLE_SCLKS - 1)) begin
                  ph_next = ACS_CONVERT;
                  cc_next = 8'h0;
               end
            end
         end
         ACS_CONVERT: begin
            cc_next = cc_reg + 8'h1;
            if (cc_reg == 8'(`ACS_CONV_CYCLES - 1)) begin
               ph_next = ACS_IDLE;
               if (fifo_mode) begin
                  // A full FIFO drops the new result rather than overwrite unread words.
                  fif.wr_en = ~thr_hit && (fif.count != 4'(`ACS_FIFO_DEPTH));
                  step_next = step_reg + 2'h1;
                  // A threshold of zero never ends a sequence.
                  if ((cfg_threshold != 4'h0) && (fif.count + 4'h1 >= cfg_threshold)) begin
                     done_next = 1'b1;
                     step_next = 2'h0;
                  end
               end else begin
                  dout_next = adc_result;
                  dv_next   = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
   end

   // Registers only.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ph_reg    <= ACS_IDLE;
         sc_reg    <= 5'h00;
         cc_reg    <= 8'h00;
         step_reg  <= 2'h0;
         chan_reg  <= 3'h0;
         chsel_reg <= 1'b0;
         done_reg  <= 1'b0;
         pd_reg    <= 1'b0;
         ign_reg   <= 1'b0;
         dv_reg    <= 1'b0;
         dout_reg  <= 12'h000;
         cfg_reg   <= `ACS_CFG_RESET;
      end else begin
         ph_reg    <= ph_next;
         sc_reg    <= sc_next;
         cc_reg    <= cc_next;
         step_reg  <= step_next;
         chan_reg  <= chan_next;
         chsel_reg <= chsel_next;
         done_reg  <= done_next;
         pd_reg    <= pd_next;
         ign_reg   <= ign_next;
         dv_reg    <= dv_next;
         dout_reg  <= dout_next;
         cfg_reg   <= cfg_next;
      end
   end

   // Outputs from registers.
   assign cmd_ignored     = ign_reg;
   assign config_register = cfg_reg;
   assign data_out        = dout_reg;
   assign data_valid      = dv_reg;
   assign mux_chan        = chan_reg;
   assign sampling        = (ph_reg == ACS_SAMPLE);
   assign converting      = (ph_reg == ACS_CONVERT);
   assign seq_done        = done_reg;
   assign powered_down    = pd_reg;
   assign fifo_count      = fif.count;
endmodule : acs_sequencer

/* File: acs_map.svh */
/*
 Constants of the conversion mode sequencer: mode codes, field widths, reset values and serial clock counts.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_MODE_SINGLE      2'h0
`define ACS_MODE_REPEAT      2'h1
`define ACS_MODE_SWEEP       2'h2
`define ACS_MODE_RSWEEP      2'h3
`define ACS_CMD_CHANSEL      3'h0
`define ACS_CMD_CONV         3'h1
`define ACS_CMD_FIFORD       3'h2
`define ACS_CMD_CFGRD        3'h3
`define ACS_CMD_CFGWR        3'h4
`define ACS_CMD_PWRDN        3'h5
`define ACS_FIFO_DEPTH       8
`define ACS_RESULT_W         12
`define ACS_CHAN_W           3
`define ACS_CFG_W            16
`define ACS_CFG_RESET        16'h0000
`define ACS_CMD_SCLKS        4
`define ACS_SAMPLE_SCLKS     12
`define ACS_CONV_TIME_NS     3600
`define ACS_CLK_PERIOD_NS    20
`define ACS_CONV_CYCLES      ((`ACS_CONV_TIME_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`endif

/* File: acs_pkg.sv */
/*
 Types of the conversion mode sequencer.
 Assumes acs_map.svh is on the include path.
*/
`include "acs_map.svh"
package acs_pkg;
   typedef logic [1:0]                  acs_mode_t;
   typedef logic [2:0]                  acs_cmd_t;
   typedef logic [`ACS_RESULT_W-1:0]    acs_result_t;
   typedef logic [`ACS_CHAN_W-1:0]      acs_chan_t;
   typedef enum logic [1:0] {ACS_IDLE, ACS_COMMAND, ACS_SAMPLE, ACS_CONVERT} acs_phase_e;
endpackage : acs_pkg

/* File: acs_fifo_if.sv */
/*
 Interface between the sequencer and its result FIFO.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface acs_fifo_if;
   import acs_pkg::*;
   logic        wr_en;
   acs_result_t wr_data;
   logic        rd_en;
   acs_result_t rd_data;
   logic        clear;
   logic [3:0]  count;
   modport seq  (output wr_en, output wr_data, output rd_en, output clear, input rd_data, input count);
   modport fifo (input wr_en, input wr_data, input rd_en, input clear, output rd_data, output count);
endinterface : acs_fifo_if

/* File: acs_result_fifo.sv */
/*
 Result FIFO of fixed depth, held in flip-flops.
 Assumes the sequencer never writes when full nor reads when empty.
*/
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_result_fifo
   import acs_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   acs_fifo_if.fifo  f
);
   acs_result_t mem_reg [`ACS_FIFO_DEPTH];
   acs_result_t mem_next [`ACS_FIFO_DEPTH];
   logic [2:0]  wp_reg, wp_next, rp_reg, rp_next;
   logic [3:0]  cnt_reg, cnt_next;

   // Pointer and storage update; clear empties the FIFO and wins over reads and writes.
   always_comb begin
      mem_next = mem_reg;
      wp_next  = wp_reg;
      rp_next  = rp_reg;
      cnt_next = cnt_reg;
      if (f.clear) begin
         wp_next  = 3'h0;
         rp_next  = 3'h0;
         cnt_next = 4'h0;
      end else begin
         if (f.wr_en) begin
            mem_next[wp_reg] = f.wr_data;
            wp_next          = wp_reg + 3'h1;
         end
         if (f.rd_en) begin
            rp_next = rp_reg + 3'h1;
         end
         cnt_next = cnt_reg + {3'h0, f.wr_en} - {3'h0, f.rd_en};
      end
   end

   // Registers only.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < `ACS_FIFO_DEPTH; i++) begin
            mem_reg[i] <= 12'h000;
         end
         wp_reg  <= 3'h0;
         rp_reg  <= 3'h0;
         cnt_reg <= 4'h0;
      end else begin
         mem_reg <= mem_next;
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   assign f.rd_data = mem_reg[rp_reg];
   assign f.count   = cnt_reg;
endmodule : acs_result_fifo

/* File: acs_seq_monitor.sv */
/*
 Checker of the conversion mode sequencer, watching only its ports.
 Assumes it is bound onto acs_sequencer, single clock domain.
*/
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_seq_monitor
   import acs_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       frame_start_n,
   input wire logic       cmd_valid,
   input wire acs_cmd_t   cmd_code,
   input wire acs_mode_t  cfg_mode,
   input wire logic [3:0] cfg_threshold,
   input wire logic       cmd_ignored,
   input wire logic       data_valid,
   input wire logic       sampling,
   input wire logic       converting,
   input wire logic       seq_done,
   input wire logic       powered_down,
   input wire logic [3:0] fifo_count
);
   logic [7:0] samp_cnt_reg;
   logic [7:0] samp_cnt_next;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Counts cycles of the sampling phase, held while converting.
   always_comb samp_cnt_next = sampling ? samp_cnt_reg + 8'h01 : (converting ? samp_cnt_reg : 8'h00);
   // Registers the sampling cycle count.
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         samp_cnt_reg <= 8'h00;
      else
         samp_cnt_reg <= samp_cnt_next;
   sweep_halt_a: assert property (cfg_mode == `ACS_MODE_SWEEP && seq_done |=> fifo_count <= $past(fifo_count))
      else $error("fifo grew after sweep done");
   sweep_refuse_a: assert property (cmd_valid && cmd_code == `ACS_CMD_CONV && cfg_mode == `ACS_MODE_SWEEP && seq_done
      |=> cmd_ignored) else $error("conversion not refused after sweep done");
   rsweep_clear_a: assert property (cmd_valid && cmd_code == `ACS_CMD_CONV && cfg_mode == `ACS_MODE_RSWEEP && seq_done
      |=> !cmd_ignored && fifo_count == 4'h0) else $error("repeat sweep did not restart");
   single_bypass_a: assert property ($fell(converting) && cfg_mode == `ACS_MODE_SINGLE
      |-> ##[0:2] (data_valid && fifo_count == 4'h0)) else $error("single shot result not bypassed");
   repeat_store_a: assert property ($fell(converting) && cfg_mode == `ACS_MODE_REPEAT |-> ##[0:2] $changed(fifo_count))
      else $error("repeat result not stored");
   frame_start_a: assert property ($fell(frame_start_n) && !sampling && !converting && cfg_mode[1] && !seq_done
      |-> ##[1:200] sampling) else $error("frame did not start a conversion");
   sample_len_a: assert property ($rose(converting) |-> samp_cnt_reg == 8'h60)
      else $error("sampling phase length wrong");
   done_count_a: assert property ($rose(seq_done) |-> fifo_count == cfg_threshold)
      else $error("done without threshold count");
   power_down_a: assert property (cmd_valid && cmd_code == `ACS_CMD_PWRDN |-> ##[1:2] powered_down)
      else $error("power down not taken");
endmodule : acs_seq_monitor
bind acs_sequencer acs_seq_monitor u_mon (.clk, .reset_n, .frame_start_n, .cmd_valid, .cmd_code, .cfg_mode,
   .cfg_threshold, .cmd_ignored, .data_valid, .sampling, .converting, .seq_done, .powered_down, .fifo_count);

/* File: acs_host_model.sv */
/*
 Host serial port model: frame or start pulse, then a burst of serial clock.
 Assumes go is a one-cycle request on clk; sclk stands low outside frames.
*/
`timescale 1ns/1ps
module acs_host_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [1:0] how,
   output logic            sclk,
   output logic            frame_start_n,
   output logic            conversion_start_pin,
   output logic            busy
);
   // Starts one conversion by frame or pin, or clocks only, then 17 serial clocks.
   initial begin
      sclk = 1'b0;
      frame_start_n = 1'b1;
      conversion_start_pin = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clk iff go);
         #1;
         busy = 1'b1;
         frame_start_n = (how != 2'h0);
         conversion_start_pin = (how != 2'h1);
         repeat (5) @(posedge clk);
         #1;
         conversion_start_pin = 1'b1;
         repeat (17) begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
         end
         frame_start_n = 1'b1;
         busy = 1'b0;
      end
   end
endmodule : acs_host_model

/* File: tb_top.sv */
/*
 Self-checking bench of the conversion mode sequencer.
 Assumes the host model supplies frames, start pulses and the serial clock.
*/
`timescale 1ns/1ps
`include "acs_map.svh"
module tb_top;
   import acs_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        cmd_valid = 1'b0;
   acs_cmd_t    cmd_code = 3'h0;
   acs_chan_t   cmd_chan = 3'h0;
   logic [15:0] cmd_cfg = 16'h0000;
   acs_mode_t   cfg_mode = 2'h0;
   logic [3:0]  cfg_threshold = 4'h0;
   logic [11:0] channel_sequence = 12'h8D1;
   acs_result_t adc_result = 12'h000;
   logic        go = 1'b0;
   logic [1:0]  how = 2'h0;
   logic        sclk, frame_start_n, conversion_start_pin, busy;
   logic        cmd_ignored, data_valid, sampling, converting, seq_done, powered_down;
   logic [15:0] config_register;
   acs_result_t data_out, last_data;
   acs_chan_t   mux_chan;
   logic [3:0]  fifo_count;
   int          fails = 0;
   int          compares = 0;
   int          cycles = 0;
   acs_sequencer u_dut (.clk, .reset_n, .sclk, .frame_start_n, .conversion_start_pin, .cmd_valid, .cmd_code,
      .cmd_chan, .cmd_cfg, .cfg_mode, .cfg_threshold, .channel_sequence, .adc_result, .cmd_ignored,
      .config_register, .data_out, .data_valid, .mux_chan, .sampling, .converting, .seq_done, .powered_down,
      .fifo_count);
   acs_host_model u_host (.clk, .go, .how, .sclk, .frame_start_n, .conversion_start_pin, .busy);
   // Makes the 50 MHz clock.
   always #10 clk = ~clk;
   // Feeds a result that names the channel, keeps the last word out and cuts a hang short.
   always @(posedge clk) begin
      adc_result <= {9'h150, mux_chan};
      if (data_valid)
         last_data <= data_out;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cmd(input acs_cmd_t c, input acs_chan_t ch = 3'h0, input logic [15:0] cf = 16'h0000);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code  <= c;
      cmd_chan  <= ch;
      cmd_cfg   <= cf;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
   endtask : cmd
   task automatic setup(input acs_mode_t m, input logic [3:0] t);
      @(posedge clk);
      cfg_mode      <= m;
      cfg_threshold <= t;
      cmd(`ACS_CMD_CFGWR, 3'h0, {12'hC3A, 2'h0, m});
      check("config", config_register, {12'hC3A, 2'h0, m});
   endtask : setup
   task automatic conv(input logic [1:0] h);
      int n;
      for (n = 0; n < 300 && busy; n++)
         @(posedge clk);
      if (h == 2'h2)
         cmd(`ACS_CMD_CONV);
      @(posedge clk);
      go  <= 1'b1;
      how <= h;
      @(posedge clk);
      go <= 1'b0;
      for (n = 0; n < 300 && !converting; n++)
         @(posedge clk);
      for (n = 0; n < 300 && converting; n++)
         @(posedge clk);
      repeat (3) @(posedge clk);
   endtask : conv
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   // Runs the tests in order.
   initial begin
      int i;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      check("reset count", fifo_count, 16'h0000);
      setup(`ACS_MODE_SWEEP, 4'h4);
      for (i = 0; i < 4; i++) begin
         conv({1'b0, i[0]});
         check("sweep count", fifo_count, 16'(i + 1));
      end
      check("sweep done", seq_done, 16'h0001);
      cmd(`ACS_CMD_CONV);
      check("conv refused", cmd_ignored, 16'h0001);
      cmd(`ACS_CMD_CHANSEL, 3'h2);
      check("chan refused", cmd_ignored, 16'h0001);
      cmd(`ACS_CMD_CFGRD);
      check("cfg read", cmd_ignored, 16'h0000);
      check("held count", fifo_count, 16'h0004);
      for (i = 0; i < 4; i++) begin
         cmd(`ACS_CMD_FIFORD);
         check("sweep order", data_out, {4'h0, 9'h150, 3'(i + 1)});
      end
      cmd(`ACS_CMD_FIFORD);
      check("empty read", data_valid, 16'h0000);
      conv(2'h1);
      check("rerun count", fifo_count, 16'h0001);
      cmd(`ACS_CMD_FIFORD);
      check("rerun chan", data_out, {4'h0, 9'h150, 3'h1});
      $display("Test sweep finished");
      setup(`ACS_MODE_RSWEEP, 4'h4);
      for (i = 0; i < 5; i++)
         conv(2'h2);
      check("restart count", fifo_count, 16'h0001);
      cmd(`ACS_CMD_FIFORD);
      check("restart chan", data_out, {4'h0, 9'h150, 3'h1});
      $display("Test repeat sweep finished");
      setup(`ACS_MODE_SINGLE, 4'h0);
      cmd(`ACS_CMD_CONV);
      check("no channel", cmd_ignored, 16'h0001);
      cmd(`ACS_CMD_CHANSEL, 3'h5);
      check("mux chan", mux_chan, 16'h0005);
      conv(2'h2);
      check("single data", last_data, {4'h0, 9'h150, 3'h5});
      check("single fifo", fifo_count, 16'h0000);
      $display("Test single shot finished");
      setup(`ACS_MODE_REPEAT, 4'h0);
      cmd(`ACS_CMD_CHANSEL, 3'h6);
      conv(2'h0);
      conv(2'h1);
      check("repeat fifo", fifo_count, 16'h0002);
      for (i = 0; i < 3; i++) begin
         if (i == 2)
            conv(2'h0);
         cmd(`ACS_CMD_FIFORD);
         check("repeat chan", data_out, {4'h0, 9'h150, 3'h6});
      end
      cmd(`ACS_CMD_PWRDN);
      repeat (2) @(posedge clk);
      check("power down", powered_down, 16'h0001);
      $display("Test repeat and power down finished");
      close_out();
   end
endmodule : tb_top
